// File: tx_confirm_status_and_pool_descriptor.sv
// What this block does
// - Host flag cleared or queue full: 1001
// - Class conflicting with ring state: 1010
// - Parity, frame control, MAC frame: abort 1011
// - Other beacon or claim lost: 1011
// - Rotation timer expiry, holding disabled: 1100
// - Holding expiry: finish frame, release token
// - MAC reset during request: 1101
// - Inconsistent descriptor queues: 1110
// - Internal fault or bus error: 1111
// - Pool address loads data unit pointer
// - Free area ends at next 4 kByte
// - Byte count field is ignored
// - Normal completion writes 0110
//
// Implementation choices: the register addresses and the plain strobed port.
`timescale 1ns/100ps
`include "txc_cfg.svh"
module tx_confirm_status_and_pool_descriptor
   import txc_pkg::*;
(
   // Clock and reset
   input wire logic sys_clk,
   input wire logic sys_rst,
   // Register port
   input wire logic [7:0] reg_addr,
   input wire logic [31:0] reg_wdata,
   input wire logic reg_wr,
   input wire logic reg_rd,
   output logic [31:0] reg_rdata,
   output logic irq,
   // Request control from the ring engine
   input wire logic req_start,
   input wire logic [1:0] req_class,
   input wire logic req_last_done,
   input wire logic frame_done,
   input wire logic ring_operational,
   input wire tx_mode_e tx_mode,
   input wire logic tht_enabled,
   input wire logic tht_expired,
   input wire logic trt_expired,
   // Abnormal conditions
   input wire logic cnf_queue_full,
   input wire logic parity_error,
   input wire logic fc_check_fail,
   input wire logic mac_frame_rx,
   input wire logic other_beacon_rx,
   input wire logic claim_lost,
   input wire logic mac_reset_hw,
   input wire logic internal_fault,
   input wire logic abus_error,
   // Output unit descriptor parts
   input wire logic output_unit_descriptor_valid,
   input wire logic [1:0] output_unit_descriptor_tag,
   // Confirmation and token
   output logic cnf_valid,
   output logic [3:0] cnf_status,
   output logic transmit_abort_out,
   output logic token_release,
   // Pool space descriptors
   input wire logic psp_valid,
   input wire logic [31:0] psp_word0,
   input wire logic [31:0] psp_word1,
   input wire logic idu_write,
   output logic [27:0] idu_ptr,
   output logic [27:0] idu_page_end,
   output logic idu_space_empty
);

   state_s s;
   state_s next_s;
   cause_if cif ();
   logic output_unit_descriptor_bad;
   logic ringop_bad;
   logic mode_abort;
   logic tht_hit;
   logic [`EV_WIDTH-1:0] events;
   logic [`EV_WIDTH-1:0] irq_hit;
   logic [`PAGE_BITS-1:0] next_page;
   logic [27:0] next_ptr;

   cause_select u_select (
      .cif(cif)
   );

   always_comb begin
      output_unit_descriptor_bad = 1'b0;
      if (output_unit_descriptor_valid) begin
         unique case (output_unit_descriptor_tag)
            `TAG_FIRST, `TAG_ONLY: output_unit_descriptor_bad = s.in_frame;
            `TAG_MIDDLE, `TAG_LAST: output_unit_descriptor_bad = !s.in_frame;
         endcase
      end
   end

   assign ringop_bad = (req_class == `CLASS_IMMEDIATE) ? ring_operational : !ring_operational;

   assign tht_hit = tht_enabled && tht_expired;

   always_comb begin
      unique case (tx_mode)
         MODE_DATA: mode_abort = mac_frame_rx;
         MODE_BEACON: mode_abort = other_beacon_rx;
         MODE_CLAIM: mode_abort = claim_lost;
         MODE_OTHER: mode_abort = 1'b0;
      endcase
   end

   // Causes count only while a request is running
   always_comb begin
      cif.causes = '0;
      if (s.phase == PH_ACTIVE) begin
         cif.causes.host_abort = !s.host_abort_flag || cnf_queue_full;
         cif.causes.dev_abort = parity_error || fc_check_fail || mode_abort;
         cif.causes.timeout = !tht_enabled && trt_expired;
         cif.causes.mac_reset = mac_reset_hw || s.soft_reset;
         cif.causes.consist = output_unit_descriptor_bad;
         cif.causes.fatal = internal_fault || abus_error;
      end
   end

   always_comb begin
      next_s = s;
      next_ptr = s.idu_ptr;
      events = '0;
      // Wraps at the top of the address space
      next_page = psp_word1[`LOC_MSB:`PAGE_LSB] + `PAGE_STEP;
      next_s.cnf_valid = 1'b0;
      next_s.tx_abort = 1'b0;
      next_s.token_release = 1'b0;
      next_s.soft_reset = 1'b0;
      next_s.rdata = '0;

      unique case (s.phase)
         PH_IDLE: begin
            if (req_start) begin
               if (ringop_bad) begin
                  next_s.cnf_valid = 1'b1;
                  next_s.cnf_status = `CODE_BAD_RINGOP;
                  next_s.last_code = `CODE_BAD_RINGOP;
                  events[`EV_CNF] = 1'b1;
                  events[`EV_ABORT] = 1'b1;
               end else begin
                  next_s.phase = PH_ACTIVE;
                  next_s.in_frame = 1'b0;
                  next_s.pending_release = 1'b0;
               end
            end
         end
         PH_ACTIVE: begin
            if (output_unit_descriptor_valid) begin
               unique case (output_unit_descriptor_tag)
                  `TAG_FIRST: next_s.in_frame = 1'b1;
                  `TAG_MIDDLE: next_s.in_frame = s.in_frame;
                  `TAG_LAST, `TAG_ONLY: next_s.in_frame = 1'b0;
               endcase
            end
            if (cif.any) begin
               next_s.phase = PH_IDLE;
               next_s.cnf_valid = 1'b1;
               next_s.cnf_status = cif.code;
               next_s.last_code = cif.code;
               next_s.tx_abort = (cif.code == `CODE_DEV_ABORT);
               events[`EV_CNF] = 1'b1;
               events[`EV_ABORT] = 1'b1;
            end else if (req_last_done) begin
               next_s.phase = PH_IDLE;
               next_s.cnf_valid = 1'b1;
               next_s.cnf_status = `CODE_OK;
               next_s.last_code = `CODE_OK;
               events[`EV_CNF] = 1'b1;
            end else begin
               if (tht_hit) begin
                  next_s.pending_release = 1'b1;
               end
               if (frame_done && (s.pending_release || tht_hit)) begin
                  next_s.token_release = 1'b1;
                  next_s.pending_release = 1'b0;
               end
            end
         end
      endcase

      if (psp_valid) begin
         next_ptr = psp_word1[`LOC_MSB:0];
         next_s.page_end = {next_page, `PAGE_ZERO};
      end else if (idu_write && !s.space_empty) begin
         next_ptr = s.idu_ptr + `IDU_STEP;
         if (next_ptr == s.page_end) begin
            events[`EV_PAGE_FULL] = 1'b1;
         end
      end
      next_s.idu_ptr = next_ptr;
      // Empty is judged against the end in force after this cycle
      next_s.space_empty = (next_ptr == next_s.page_end);

      if (reg_wr) begin
         unique case (reg_addr)
            `OFS_CTRL: begin
               next_s.host_abort_flag = reg_wdata[`CTRL_HOST_ABORT_BIT];
               next_s.soft_reset = reg_wdata[`CTRL_SOFT_RESET_BIT];
            end
            `OFS_IRQ_EN: begin
               next_s.irq_en = reg_wdata[`EV_WIDTH-1:0];
            end
            // Write one to clear
            `OFS_IRQ_CLR: begin
               next_s.irq_stat = s.irq_stat & ~reg_wdata[`EV_WIDTH-1:0];
            end
            default: ;
         endcase
      end
      // New events win over a clear in the same cycle
      next_s.irq_stat = next_s.irq_stat | events;

      if (reg_rd) begin
         unique case (reg_addr)
            `OFS_CTRL: begin
               next_s.rdata[`CTRL_HOST_ABORT_BIT] = s.host_abort_flag;
            end
            `OFS_IRQ_STAT: begin
               next_s.rdata[`EV_WIDTH-1:0] = s.irq_stat;
            end
            `OFS_IRQ_EN: begin
               next_s.rdata[`EV_WIDTH-1:0] = s.irq_en;
            end
            `OFS_LAST_CODE: begin
               next_s.rdata[`CODE_MSB:0] = s.last_code;
            end
            `OFS_IDU_PTR: begin
               next_s.rdata[`LOC_MSB:0] = s.idu_ptr;
            end
            `OFS_PAGE_END: begin
               next_s.rdata[`LOC_MSB:0] = s.page_end;
            end
            default: next_s.rdata = '0;
         endcase
      end
   end

   always_ff @(posedge sys_clk or posedge sys_rst) begin
      if (sys_rst) begin
         s <= '{
            phase: PH_IDLE,
            pending_release: 1'b0,
            in_frame: 1'b0,
            host_abort_flag: `CTRL_RESET_VAL,
            soft_reset: 1'b0,
            irq_stat: '0,
            irq_en: '0,
            last_code: `CODE_NONE,
            idu_ptr: `PTR_ZERO,
            page_end: `PTR_ZERO,
            // No space until the first pool descriptor
            space_empty: 1'b1,
            rdata: '0,
            cnf_valid: 1'b0,
            cnf_status: `CODE_NONE,
            tx_abort: 1'b0,
            token_release: 1'b0
         };
      end else begin
         s <= next_s;
      end
   end

   assign reg_rdata = s.rdata;
   // One enable gate per event bit
   for (genvar i = 0; i < `EV_WIDTH; i++) begin : g_irq
      assign irq_hit[i] = s.irq_stat[i] & s.irq_en[i];
   end
   assign irq = |irq_hit;
   assign cnf_valid = s.cnf_valid;
   assign cnf_status = s.cnf_status;
   assign transmit_abort_out = s.tx_abort;
   assign token_release = s.token_release;
   assign idu_ptr = s.idu_ptr;
   assign idu_page_end = s.page_end;
   assign idu_space_empty = s.space_empty;

endmodule

// File: txc_cfg.svh
`ifndef TXC_CFG_SVH
`define TXC_CFG_SVH

// Confirmation status codes
`define CODE_OK 4'h6
`define CODE_HOST_ABORT 4'h9
`define CODE_BAD_RINGOP 4'ha
`define CODE_DEV_ABORT 4'hb
`define CODE_TIMEOUT 4'hc
`define CODE_MAC_RESET 4'hd
`define CODE_CONSIST 4'he
`define CODE_FATAL 4'hf
`define CODE_NONE 4'h0
`define CODE_MSB 3

// Register byte offsets
`define OFS_CTRL 8'h00
`define OFS_IRQ_STAT 8'h04
`define OFS_IRQ_EN 8'h08
`define OFS_IRQ_CLR 8'h0c
`define OFS_LAST_CODE 8'h10
`define OFS_IDU_PTR 8'h14
`define OFS_PAGE_END 8'h18

// Control register fields
`define CTRL_HOST_ABORT_BIT 0
`define CTRL_SOFT_RESET_BIT 1
`define CTRL_RESET_VAL 1'b1

// Interrupt event bits
`define EV_CNF 0
`define EV_ABORT 1
`define EV_PAGE_FULL 2
`define EV_WIDTH 3

// Pool space descriptor word 1 fields
`define LOC_MSB 27
`define PAGE_LSB 12
`define PAGE_BITS 16
`define PAGE_STEP 16'h0001
`define PAGE_ZERO 12'h000
`define IDU_STEP 28'h0000004
`define PTR_ZERO 28'h0000000

// Service classes
`define CLASS_IMMEDIATE 2'h0

// Output unit descriptor part tags
`define TAG_MIDDLE 2'h0
`define TAG_LAST 2'h1
`define TAG_FIRST 2'h2
`define TAG_ONLY 2'h3

`endif

// File: txc_pkg.sv
package txc_pkg;

   typedef enum logic [1:0] {MODE_DATA, MODE_BEACON, MODE_CLAIM, MODE_OTHER} tx_mode_e;

   typedef enum logic {PH_IDLE, PH_ACTIVE} req_phase_e;

   typedef struct packed {
      logic mac_reset;
      logic fatal;
      logic consist;
      logic dev_abort;
      logic timeout;
      logic host_abort;
   } cause_s;

   typedef struct packed {
      req_phase_e phase;
      logic pending_release;
      logic in_frame;
      logic host_abort_flag;
      logic soft_reset;
      logic [2:0] irq_stat;
      logic [2:0] irq_en;
      logic [3:0] last_code;
      logic [27:0] idu_ptr;
      logic [27:0] page_end;
      logic space_empty;
      logic [31:0] rdata;
      logic cnf_valid;
      logic [3:0] cnf_status;
      logic tx_abort;
      logic token_release;
   } state_s;

endpackage

// File: cause_if.sv
`timescale 1ns/100ps
interface cause_if;
   import txc_pkg::*;
   cause_s causes;
   logic any;
   logic [3:0] code;
   modport sel (input causes, output any, code);
   modport user (output causes, input any, code);
endinterface

// File: cause_select.sv
`timescale 1ns/100ps
`include "txc_cfg.svh"
module cause_select
   import txc_pkg::*;
(
   // Cause vector in, code out
   cause_if.sel cif
);

   // Ties between causes in one cycle go to the most severe
   always_comb begin
      cif.any = |cif.causes;
      if (cif.causes.mac_reset) begin
         cif.code = `CODE_MAC_RESET;
      end else if (cif.causes.fatal) begin
         cif.code = `CODE_FATAL;
      end else if (cif.causes.consist) begin
         cif.code = `CODE_CONSIST;
      end else if (cif.causes.dev_abort) begin
         cif.code = `CODE_DEV_ABORT;
      end else if (cif.causes.timeout) begin
         cif.code = `CODE_TIMEOUT;
      end else if (cif.causes.host_abort) begin
         cif.code = `CODE_HOST_ABORT;
      end else begin
         cif.code = `CODE_NONE;
      end
   end

endmodule

// File: txc_props.sv
`timescale 1ns/100ps
module txc_props (
   // Clock and reset
   input wire logic sys_clk,
   input wire logic sys_rst,
   // Watched ports
   input wire logic frame_done,
   input wire logic cnf_valid,
   input wire logic [3:0] cnf_status,
   input wire logic transmit_abort_out,
   input wire logic token_release,
   input wire logic psp_valid,
   input wire logic [31:0] psp_word1,
   input wire logic idu_write,
   input wire logic [27:0] idu_ptr,
   input wire logic [27:0] idu_page_end,
   input wire logic idu_space_empty
);
   default clocking
      @(posedge sys_clk);
   endclocking
   default disable iff (sys_rst);
   chk_abort_code: assert property (
      transmit_abort_out |-> cnf_valid && cnf_status == 4'hb) else $error("Abort without code");
   chk_code_legal: assert property (
      cnf_valid |-> cnf_status == 4'h6 || cnf_status >= 4'h9) else $error("Illegal code");
   chk_status_hold: assert property (
      !cnf_valid |-> $stable(cnf_status)) else $error("Status moved");
   chk_ptr_load: assert property (
      psp_valid |=> idu_ptr == $past(psp_word1[27:0])) else $error("Pointer not loaded");
   chk_page_end: assert property (
      psp_valid |=> idu_page_end == {$past(psp_word1[27:12]) + 16'h1, 12'h0})
      else $error("Wrong page end");
   chk_ptr_step: assert property (
      idu_write && !psp_valid && !idu_space_empty |=> idu_ptr == $past(idu_ptr) + 28'h4)
      else $error("Pointer step");
   chk_full_hold: assert property (
      idu_write && !psp_valid && idu_space_empty |=> $stable(idu_ptr)) else $error("Write past end");
   chk_release_frame: assert property (
      token_release |-> $past(frame_done)) else $error("Release before frame end");
endmodule

bind tx_confirm_status_and_pool_descriptor txc_props u_props (.sys_clk(sys_clk),
   .sys_rst(sys_rst), .frame_done(frame_done), .cnf_valid(cnf_valid), .cnf_status(cnf_status),
   .transmit_abort_out(transmit_abort_out), .token_release(token_release),
   .psp_valid(psp_valid), .psp_word1(psp_word1), .idu_write(idu_write), .idu_ptr(idu_ptr),
   .idu_page_end(idu_page_end), .idu_space_empty(idu_space_empty));

// File: pool_host.sv
`timescale 1ns/100ps
module pool_host (
   // Clock and reset
   input wire logic sys_clk,
   input wire logic sys_rst,
   // Bench request
   input wire logic go,
   input wire logic [27:0] buffer_address_field,
   // Descriptor out
   output logic psp_valid,
   output logic [31:0] psp_word0,
   output logic [31:0] psp_word1
);
   always_ff @(posedge sys_clk or posedge sys_rst) begin
      if (sys_rst) begin
         psp_valid <= 1'h0;
         psp_word0 <= '0;
         psp_word1 <= '0;
      end else if (go) begin
         psp_valid <= 1'h1;
         psp_word0 <= {19'h0, 13'h1000 - {1'h0, buffer_address_field[11:0]}};
         psp_word1 <= {2'h3, 2'h0, buffer_address_field[27:5], 5'h0};
      end else begin
         // Released lines must not hold
         psp_valid <= 1'h0;
         psp_word0 <= ~psp_word0;
         psp_word1 <= ~psp_word1;
      end
   end
endmodule

// File: tb_tx_confirm_status_and_pool_descriptor.sv
`timescale 1ns/100ps
module tb_tx_confirm_status_and_pool_descriptor;
   import txc_pkg::*;
   logic sys_clk = 1'h0, sys_rst = 1'h1, reg_wr = 1'h0, reg_rd = 1'h0, req_start = 1'h0;
   logic ring_operational = 1'h1, tht_enabled = 1'h0, tht_expired = 1'h0, frame_done = 1'h0;
   logic idu_write = 1'h0, go = 1'h0;
   logic [7:0] reg_addr = '0;
   logic [31:0] reg_wdata = '0;
   logic [1:0] req_class = '0;
   logic [1:0] tag = '0;
   logic [11:0] cz = '0;
   logic [27:0] buffer_address_field = '0;
   tx_mode_e tx_mode = MODE_OTHER;
   logic [31:0] reg_rdata, psp_word0, psp_word1;
   logic irq, cnf_valid, transmit_abort_out, token_release, psp_valid, idu_space_empty;
   logic [3:0] cnf_status;
   logic [27:0] idu_ptr, idu_page_end;
   int fails = 0, checked = 0, cycles = 0;
   tx_confirm_status_and_pool_descriptor dut (.sys_clk(sys_clk), .sys_rst(sys_rst),
      .reg_addr(reg_addr), .reg_wdata(reg_wdata), .reg_wr(reg_wr), .reg_rd(reg_rd),
      .reg_rdata(reg_rdata), .irq(irq), .req_start(req_start), .req_class(req_class),
      .req_last_done(cz[11]), .frame_done(frame_done), .ring_operational(ring_operational),
      .tx_mode(tx_mode), .tht_enabled(tht_enabled), .tht_expired(tht_expired),
      .trt_expired(cz[6]), .cnf_queue_full(cz[0]), .parity_error(cz[1]),
      .fc_check_fail(cz[2]), .mac_frame_rx(cz[3]), .other_beacon_rx(cz[4]),
      .claim_lost(cz[5]), .mac_reset_hw(cz[7]), .internal_fault(cz[9]),
      .abus_error(cz[10]), .output_unit_descriptor_valid(cz[8]), .output_unit_descriptor_tag(tag), .cnf_valid(cnf_valid),
      .cnf_status(cnf_status), .transmit_abort_out(transmit_abort_out),
      .token_release(token_release), .psp_valid(psp_valid), .psp_word0(psp_word0),
      .psp_word1(psp_word1), .idu_write(idu_write), .idu_ptr(idu_ptr),
      .idu_page_end(idu_page_end), .idu_space_empty(idu_space_empty));
   pool_host host (.sys_clk(sys_clk), .sys_rst(sys_rst), .go(go), .buffer_address_field(buffer_address_field),
      .psp_valid(psp_valid), .psp_word0(psp_word0), .psp_word1(psp_word1));
   initial forever #10 sys_clk = ~sys_clk;
   task automatic cmp(input logic [31:0] got, input logic [31:0] exp);
      checked++;
      if (got !== exp) begin
         fails++;
         $display("[FAIL] %0t got %h expected %h", $time, got, exp);
      end
   endtask
   task automatic kick(input logic [7:0] a, input logic [31:0] d);
      reg_wr <= 1'h1;
      reg_addr <= a;
      reg_wdata <= d;
      @(posedge sys_clk);
      reg_wr <= 1'h0;
   endtask
   task automatic wr(input logic [7:0] a, input logic [31:0] d);
      @(posedge sys_clk);
      kick(a, d);
   endtask
   task automatic rd(input logic [7:0] a, input logic [31:0] e);
      @(posedge sys_clk);
      reg_rd <= 1'h1;
      reg_addr <= a;
      @(posedge sys_clk);
      reg_rd <= 1'h0;
      @(negedge sys_clk);
      cmp(reg_rdata, e);
   endtask
   task automatic start(input logic [1:0] c);
      @(posedge sys_clk);
      req_start <= 1'h1;
      req_class <= c;
      @(posedge sys_clk);
      req_start <= 1'h0;
   endtask
   task automatic await(input logic [3:0] e);
      repeat (20) begin
         @(negedge sys_clk);
         if (cnf_valid === 1'h1) break;
      end
      cmp(cnf_valid, 1);
      cmp(cnf_status, e);
      cmp(transmit_abort_out, e == 4'hb);
      @(posedge sys_clk);
      cz <= '0;
   endtask
   task automatic t_causes;
      logic [3:0] ex [12] = '{4'h9, 4'hb, 4'hb, 4'hb, 4'hb, 4'hb, 4'hc, 4'hd, 4'he, 4'hf,
         4'hf, 4'h6};
      for (int i = 0; i < 12; i++) begin
         tx_mode <= i == 3 ? MODE_DATA : i == 4 ? MODE_BEACON : i == 5 ? MODE_CLAIM : MODE_OTHER;
         start(2'h1);
         cz[i] <= 1'h1;
         await(ex[i]);
      end
      start(2'h1);
      cz <= 12'h082;
      await(4'hd);
      start(2'h1);
      cz <= 12'h808;
      await(4'h6);
      $display("causes test done");
   endtask
   task automatic t_parts;
      // Well formed parts: first, middle, last, only
      start(2'h1);
      cz[8] <= 1'h1;
      tag <= 2'h2;
      @(posedge sys_clk);
      tag <= 2'h0;
      @(posedge sys_clk);
      tag <= 2'h1;
      @(posedge sys_clk);
      tag <= 2'h3;
      @(posedge sys_clk);
      cz <= 12'h800;
      await(4'h6);
      // First held two cycles is two firsts
      start(2'h1);
      cz[8] <= 1'h1;
      tag <= 2'h2;
      await(4'he);
      $display("parts test done");
   endtask
   task automatic t_ringop;
      start(2'h0);
      await(4'ha);
      ring_operational <= 1'h0;
      start(2'h3);
      await(4'ha);
      start(2'h0);
      cz[11] <= 1'h1;
      await(4'h6);
      ring_operational <= 1'h1;
      $display("ring state test done");
   endtask
   task automatic t_host;
      cmp(cnf_status, 4'h6);
      rd(8'h00, 32'h1);
      wr(8'h08, 32'h7);
      start(2'h1);
      kick(8'h00, 32'h0);
      await(4'h9);
      start(2'h1);
      await(4'h9);
      rd(8'h04, 32'h3);
      cmp(irq, 1);
      wr(8'h0c, 32'h7);
      @(negedge sys_clk);
      cmp(irq, 0);
      rd(8'h1c, 32'h0);
      wr(8'h00, 32'h1);
      start(2'h1);
      kick(8'h00, 32'h3);
      await(4'hd);
      $display("host abort test done");
   endtask
   task automatic t_token;
      tht_enabled <= 1'h1;
      start(2'h1);
      tht_expired <= 1'h1;
      @(posedge sys_clk);
      tht_expired <= 1'h0;
      frame_done <= 1'h1;
      @(posedge sys_clk);
      frame_done <= 1'h0;
      @(negedge sys_clk);
      cmp(token_release, 1);
      cmp(cnf_valid, 0);
      @(posedge sys_clk);
      cz[11] <= 1'h1;
      await(4'h6);
      tht_enabled <= 1'h0;
      $display("token test done");
   endtask
   task automatic load(input logic [27:0] a);
      @(posedge sys_clk);
      go <= 1'h1;
      buffer_address_field <= a;
      @(posedge sys_clk);
      go <= 1'h0;
      @(posedge sys_clk);
      @(negedge sys_clk);
      cmp(idu_ptr, a);
   endtask
   task automatic t_pool;
      wr(8'h0c, 32'h7);
      load(28'h0001240);
      cmp(idu_page_end, 28'h0002000);
      @(posedge sys_clk);
      idu_write <= 1'h1;
      // One write beyond the page end
      repeat (881) @(posedge sys_clk);
      idu_write <= 1'h0;
      @(negedge sys_clk);
      cmp(idu_ptr, 28'h0002000);
      cmp(idu_space_empty, 1);
      rd(8'h04, 32'h4);
      load(28'h0003000);
      cmp(idu_page_end, 28'h0004000);
      cmp(idu_space_empty, 0);
      $display("pool test done");
   endtask
   task automatic end_of_test;
      $display("checked %0d fails %0d", checked, fails);
      if (fails == 0 && checked > 0) begin
         $display("All tests passed");
      end else begin
         $display("Some tests failed");
      end
      $finish;
   endtask
   // Whole run needs about 1000 cycles
   always @(posedge sys_clk) begin
      cycles++;
      if (cycles == 20000) begin
         fails++;
         end_of_test;
      end
   end
   initial begin
      repeat (10) @(posedge sys_clk);
      sys_rst <= 1'h0;
      @(posedge sys_clk);
      t_causes;
      t_parts;
      t_ringop;
      t_host;
      t_token;
      t_pool;
      end_of_test;
   end
endmodule
